//--- hdl/fbsm_pkg.sv
package fbsm_pkg;

  // ****************************************
  // Variant limits
  // ****************************************
  localparam logic [15:0] FBSM_RW_SECT_END_64  = 16'h6fff;
  localparam logic [15:0] FBSM_NR_SECT_BEG_64  = 16'h7000;
  localparam logic [15:0] FBSM_RW_SECT_END_128 = 16'hefff;
  localparam logic [15:0] FBSM_NR_SECT_BEG_128 = 16'hf000;
  localparam int          FBSM_PC_TOP_64    = 14;
  localparam int          FBSM_PC_TOP_128   = 15;
  localparam int          FBSM_WORD_TOP     = 6;
  localparam int          FBSM_PAGE_WORDS   = 128;

  // Boot starts per fuse code 11,10,01,00
  localparam logic [15:0] FBSM_BOOT_64_11  = 16'h7e00;
  localparam logic [15:0] FBSM_BOOT_64_10  = 16'h7c00;
  localparam logic [15:0] FBSM_BOOT_64_01  = 16'h7800;
  localparam logic [15:0] FBSM_BOOT_64_00  = 16'h7000;
  localparam logic [15:0] FBSM_BOOT_128_11 = 16'hfe00;
  localparam logic [15:0] FBSM_BOOT_128_10 = 16'hfc00;
  localparam logic [15:0] FBSM_BOOT_128_01 = 16'hf800;
  localparam logic [15:0] FBSM_BOOT_128_00 = 16'hf000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        store;
    logic        load;
    logic        page_op;
    logic        fetch;
    logic        ext_bit;
    logic [15:0] pointer;
  } fbsm_req_t;

  typedef struct packed {
    logic [8:0]  page_select;
    logic [6:0]  word_select;
    logic        byte_select;
    logic        in_rww;
    logic        in_boot;
    logic        pointer_fault;
  } fbsm_map_t;

  typedef struct packed {
    logic [15:0] boot_start;
    logic [15:0] app_end;
  } fbsm_boot_t;

endpackage

//--- hdl/fbsm_boot_dec.sv
`timescale 1ns/10ps
module fbsm_boot_dec
  import fbsm_pkg::*;
#(
  parameter bit BIG = 1'b0
) (
  input  wire logic            mclk,
  input  wire logic            reset_n,
  input  wire logic            clk_en,
  input  wire logic [1:0]      fuse_code,
  output fbsm_pkg::fbsm_boot_t boot
);
  // ****************************************
  // Registered boot bound table
  // ****************************************
  // Code 00 is the default, so an unknown code gives the largest boot area
  function automatic logic [15:0] boot_start_of(input logic [1:0] code);
    logic [15:0] start;
    case (code)
      2'b11:   start = BIG ? FBSM_BOOT_128_11 : FBSM_BOOT_64_11;
      2'b10:   start = BIG ? FBSM_BOOT_128_10 : FBSM_BOOT_64_10;
      2'b01:   start = BIG ? FBSM_BOOT_128_01 : FBSM_BOOT_64_01;
      default: start = BIG ? FBSM_BOOT_128_00 : FBSM_BOOT_64_00;
    endcase
    return start;
  endfunction

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      boot <= '0;
    end else if (clk_en) begin
      boot.boot_start <= boot_start_of(fuse_code);
      // Application section ends one word below the boot start
      boot.app_end    <= boot_start_of(fuse_code) - 16'h0001;
    end
  end
endmodule

//--- hdl/fbsm_map.sv
`timescale 1ns/10ps
module fbsm_map #(
  parameter bit BIG = 1'b0
) (
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire logic               clk_en,
  input  wire logic               boot_size_fuse_hi,
  input  wire logic               boot_size_fuse_lo,
  input  wire fbsm_pkg::fbsm_req_t req,
  input  wire logic               op_start,
  input  wire logic               op_done,
  input  wire logic               rww_reenable,
  input  wire logic               page_load,
  output fbsm_pkg::fbsm_map_t     map,
  output fbsm_pkg::fbsm_boot_t    boot,
  output logic                    rww_busy_flag,
  output logic                    rww_access_block,
  output logic                    cpu_halt
);
  import fbsm_pkg::*;

  // ****************************************
  // Address decode helpers
  // ****************************************
  localparam logic [15:0] RW_SECT_END = BIG ? FBSM_RW_SECT_END_128 :
                                              FBSM_RW_SECT_END_64;
  localparam logic [15:0] NR_SECT_BEG = BIG ? FBSM_NR_SECT_BEG_128 :
                                              FBSM_NR_SECT_BEG_64;
  localparam int          PC_TOP      = BIG ? FBSM_PC_TOP_128 : FBSM_PC_TOP_64;
  // 64k has no PC bit 15, so the extension bit is dropped there
  localparam logic [15:0] PC_MASK     = 16'hffff >> (15 - PC_TOP);
  localparam logic [15:0] PAGE_MASK   = 16'(FBSM_PAGE_WORDS - 1);

  // Pointer bit n+1 carries PC bit n, the extension bit the top one
  function automatic logic [15:0] pc_of(input logic        ext,
                                        input logic [15:0] z);
    logic [15:0] pc;
    pc = {ext, z[15:1]} & PC_MASK;
    return pc;
  endfunction

  function automatic logic rww_hit(input logic [15:0] pc);
    return pc <= RW_SECT_END;
  endfunction

  logic [15:0] req_pc;
  logic [1:0]  fuse_q1;
  logic [1:0]  fuse_q2;
  logic [1:0]  fuse_q3;
  logic [1:0]  fuse_code;
  logic        op_in_rww;
  logic        op_active;

  assign req_pc = pc_of(req.ext_bit, req.pointer);

  // ****************************************
  // Fuse synchroniser
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fuse_q1   <= 2'h0;
      fuse_q2   <= 2'h0;
      fuse_q3   <= 2'h0;
      fuse_code <= 2'h0;
    end else if (clk_en) begin
      fuse_q1 <= {boot_size_fuse_hi, boot_size_fuse_lo};
      fuse_q2 <= fuse_q1;
      fuse_q3 <= fuse_q2;
      if (fuse_q2 == fuse_q3) begin
        fuse_code <= fuse_q3;
      end
    end
  end

  fbsm_boot_dec #(
    .BIG(BIG)
  ) u_boot (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .fuse_code (fuse_code),
    .boot      (boot)
  );

  // ****************************************
  // Pointer mapping
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      map <= '0;
    end else if (clk_en) begin
      map.word_select <= req_pc[FBSM_WORD_TOP:0];
      map.page_select <= BIG ? req_pc[15:7] : {1'b0, req_pc[14:7]};
      // Byte select only for loads; stores always see word 0 byte
      map.byte_select <= req.load & req.pointer[0];
      map.in_rww      <= rww_hit(req_pc);
      map.in_boot     <= req_pc >= boot.boot_start;
      // Flag a store with odd pointer, or a page op with word bits set
      map.pointer_fault <= (req.store & req.pointer[0]) |
                           (req.page_op & (req_pc[6:0] != 7'h00));
    end
  end

  // ****************************************
  // Busy flag and halt
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      op_active <= 1'b0;
      op_in_rww <= 1'b0;
    end else if (clk_en) begin
      if (op_start) begin
        op_active <= 1'b1;
        op_in_rww <= rww_hit(req_pc);
      end else if (op_done) begin
        op_active <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rww_busy_flag <= 1'b0;
    end else if (clk_en) begin
      // Set wins over a clear in the same cycle
      if (op_start && rww_hit(req_pc)) begin
        rww_busy_flag <= 1'b1;
      end else if (page_load || (rww_reenable && !op_active)) begin
        rww_busy_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rww_access_block <= 1'b0;
      cpu_halt         <= 1'b0;
    end else if (clk_en) begin
      rww_access_block <= rww_busy_flag & (req.fetch | req.load) &
                          rww_hit(req_pc);
      // Writes into the no-read-while-write section stall the core
      cpu_halt <= (op_start & !rww_hit(req_pc)) |
                  (op_active & !op_in_rww & !op_done);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Steps of a self-programming operation, shared by the checks below
  sequence s_rw_op_start;
    clk_en && op_start && rww_hit(req_pc);
  endsequence

  sequence s_nr_op_start;
    clk_en && op_start && !rww_hit(req_pc);
  endsequence

  sequence s_nr_op_finish;
    clk_en && op_active && !op_in_rww && op_done && !op_start;
  endsequence

  sequence s_busy_access;
    clk_en && rww_busy_flag && (req.load || req.fetch) && rww_hit(req_pc);
  endsequence

  sequence s_busy_clear;
    clk_en && !(op_start && rww_hit(req_pc)) &&
    (page_load || (rww_reenable && !op_active));
  endsequence

  // Re-enable while the flash is still busy must leave the flag set
  sequence s_refused_clear;
    clk_en && rww_busy_flag && !page_load && !op_start &&
    rww_reenable && op_active;
  endsequence

  chk_busy_set: assert property (
    @(posedge mclk) disable iff (!reset_n)
    s_rw_op_start |=> rww_busy_flag)
    else $error("busy flag not set after section write");

  chk_busy_blocks: assert property (
    @(posedge mclk) disable iff (!reset_n)
    s_busy_access |=> rww_access_block)
    else $error("access to busy section not blocked");

  chk_busy_clear: assert property (
    @(posedge mclk) disable iff (!reset_n)
    s_busy_clear |=> !rww_busy_flag)
    else $error("busy flag not cleared");

  chk_clear_refused: assert property (
    @(posedge mclk) disable iff (!reset_n)
    s_refused_clear |=> rww_busy_flag)
    else $error("busy flag cleared while flash busy");

  chk_nr_halt: assert property (
    @(posedge mclk) disable iff (!reset_n)
    s_nr_op_start |=> cpu_halt)
    else $error("write into stalling section did not halt cpu");

  chk_halt_holds: assert property (
    @(posedge mclk) disable iff (!reset_n)
    clk_en && op_active && !op_in_rww && !op_done |=> cpu_halt)
    else $error("cpu halt dropped during write");

  chk_halt_release: assert property (
    @(posedge mclk) disable iff (!reset_n)
    s_nr_op_finish |=> !cpu_halt)
    else $error("cpu halt held after write finished");

  chk_word_map: assert property (
    @(posedge mclk) disable iff (!reset_n)
    clk_en |=> map.word_select == $past(req.pointer[7:1]))
    else $error("word select wrong");

  chk_page_size: assert property (
    @(posedge mclk) disable iff (!reset_n)
    clk_en |=> {9'h000, map.word_select} == ($past(req_pc) & PAGE_MASK))
    else $error("word select does not span one page");

  chk_page_map: assert property (
    @(posedge mclk) disable iff (!reset_n)
    clk_en |=> map.page_select == (BIG ?
      $past({req.ext_bit, req.pointer[15:8]}) :
      {1'b0, $past(req.pointer[15:8])}))
    else $error("page select wrong");

  chk_byte_select: assert property (
    @(posedge mclk) disable iff (!reset_n)
    clk_en |=> map.byte_select == $past(req.load && req.pointer[0]))
    else $error("byte select wrong");

  chk_section_split: assert property (
    @(posedge mclk) disable iff (!reset_n)
    clk_en |=> map.in_rww == ($past(req_pc) < NR_SECT_BEG))
    else $error("section split wrong");
endmodule

//--- verification/fbsm_cpu_model.sv
`timescale 1ns/10ps
module fbsm_cpu_model
  import fbsm_pkg::*;
(
  input  wire logic           load,
  input  wire logic           page_op,
  input  wire logic [16:0]    addr,
  output fbsm_pkg::fbsm_req_t req
);
  // Behaves like well-formed software, so refusals are not exercised here
  assign req = '{store: !load, load: load, page_op: page_op, fetch: 1'b0,
    ext_bit: addr[16], pointer: {addr[15:8],
    page_op ? 7'h00 : addr[7:1], load & addr[0]}};
endmodule

//--- verification/fbsm_map_tb.sv
`timescale 1ns/10ps
module fbsm_map_tb;
  import fbsm_pkg::*;
  logic        mclk, reset_n, fuse_hi, fuse_lo, load, page_op;
  logic        op_start, op_done, reenable, page_load;
  logic [16:0] addr;
  logic [31:0] rnd;
  logic [19:0] want;
  int          fails, comparisons;
  fbsm_req_t   req;
  fbsm_map_t   map [2];
  fbsm_boot_t  boot [2];
  logic        busy [2], blk [2], halt [2];
  logic [16:0] corner [4] = '{17'h0dffe, 17'h0e000, 17'h1dffe, 17'h1e000};

  // ****************************************
  // Both size variants see the same stimulus
  // ****************************************
  fbsm_cpu_model i_cpu (.load(load), .page_op(page_op), .addr(addr),
    .req(req));
  for (genvar g = 0; g < 2; g++) begin : g_v
    fbsm_map #(.BIG(g == 1)) i_dut (.mclk(mclk), .reset_n(reset_n),
      .clk_en(1'b1), .boot_size_fuse_hi(fuse_hi),
      .boot_size_fuse_lo(fuse_lo), .req(req), .op_start(op_start),
      .op_done(op_done), .rww_reenable(reenable), .page_load(page_load),
      .map(map[g]), .boot(boot[g]), .rww_busy_flag(busy[g]),
      .rww_access_block(blk[g]), .cpu_halt(halt[g]));
  end

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] bs(bit big, logic [1:0] c);
    return (big ? 16'hf000 : 16'h7000) + 16'h1000
      - (16'h0200 << (2'd3 - c));
  endfunction

  function automatic logic [18:0] exp_map(bit big, logic ld,
                                          logic [16:0] a, logic [1:0] c);
    logic [15:0] pc;
    pc = {big & a[16], a[15:1]};
    return {pc[15:7], pc[6:0], ld & a[0],
      pc <= (big ? 16'hefff : 16'h6fff), pc >= bs(big, c)};
  endfunction

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic step(int n);
    repeat (n) @(negedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    step(3000);
    fails++;
    tally_and_finish();
  end

  initial begin
    {reset_n, fuse_hi, fuse_lo, op_start, op_done, reenable} = '0;
    {page_load, load, page_op, addr} = '0;
    rnd = 32'h2174;
    step(4);
    reset_n = 1'b1;
    for (int c = 0; c < 4; c++) begin
      {fuse_hi, fuse_lo} = c[1:0];
      // Fuses pass a synchroniser, so allow the settle time first
      step(8);
      for (int i = 0; i < 2; i++) begin
        chk(boot[i].boot_start, bs(i[0], c[1:0]));
        chk(boot[i].app_end, bs(i[0], c[1:0]) - 16'h1);
      end
      for (int k = 0; k < 40; k++) begin
        rnd = lfsr(rnd);
        {load, addr} = rnd[17:0];
        if (k < 4) addr = corner[k];
        step(1);
        for (int i = 0; i < 2; i++) begin
          // Well-formed software never raises the pointer fault
          want = {exp_map(i[0], load, addr, c[1:0]), 1'b0};
          chk(map[i], want);
        end
      end
    end
    for (int k = 0; k < 2; k++) begin
      {load, page_op, addr} = {2'b01, 17'h00100};
      op_start = 1'b1;
      step(1);
      {op_start, load, page_op} = 3'b010;
      step(2);
      chk({busy[0], busy[1], blk[0], blk[1]}, 4'hf);
      reenable = 1'b1;
      step(1);
      reenable = 1'b0;
      step(1);
      chk({busy[0], busy[1]}, 2'b11);
      op_done = 1'b1;
      step(1);
      {op_done, reenable, page_load} = {1'b0, k == 0, k == 1};
      step(1);
      {reenable, page_load} = 2'b00;
      step(2);
      chk({busy[0], busy[1], blk[0], blk[1]}, 4'h0);
    end
    {load, page_op, addr} = {2'b01, 17'h1e000};
    op_start = 1'b1;
    step(1);
    op_start = 1'b0;
    step(3);
    chk({halt[0], halt[1], busy[0], busy[1]}, 4'hc);
    op_done = 1'b1;
    step(1);
    op_done = 1'b0;
    step(2);
    chk({halt[0], halt[1]}, 2'b00);
    tally_and_finish();
  end
endmodule
